// >>> sfce_defs.svh
// constants for the servo fault code encoder
`ifndef SFCE_DEFS_SVH
`define SFCE_DEFS_SVH
// apb byte offsets
`define SFCE_OFF_CTRL 12'h000
`define SFCE_OFF_STAT 12'h004
`define SFCE_OFF_CFG 12'h008
`define SFCE_OFF_RAW 12'h00C
// ctrl fields
`define SFCE_CTRL_CLR_BIT 0
// cfg fields
`define SFCE_CFG_CSEL_BIT 0
`define SFCE_CFG_PIN_LSB 4
`define SFCE_CFG_PIN_W 2
`define SFCE_CFG_RESET 32'h0000_0001
// stat fields
`define SFCE_STAT_CODE_LSB 0
`define SFCE_STAT_FAULT_BIT 4
`define SFCE_STAT_CAUT_BIT 5
`define SFCE_STAT_PANEL_BIT 6
`define SFCE_STAT_LATCH_BIT 7
// three bit codes, bit0 is lsb
`define SFCE_CODE_UV 3'h4
`define SFCE_CODE_OS 3'h5
`define SFCE_CODE_OL 3'h7
`define SFCE_CODE_ENC 3'h0
`define SFCE_CODE_LINK 3'h5
`define SFCE_CODE_DEV 3'h3
`define SFCE_CODE_OPT 3'h6
`define SFCE_CODE_PH 3'h2
`define SFCE_CODE_W_OL 3'h1
`define SFCE_CODE_W_RG 3'h2
`define SFCE_CODE_W_BAT 3'h3
// a/d conversion timeout
`define SFCE_AD_TMO_US 100
`define SFCE_AD_TMO_CYC ((`SFCE_AD_TMO_US * 100))
`define SFCE_NFAULT 28
`endif

// >>> sfce_pkg.sv
// types for the servo fault code encoder
package sfce_pkg;
    // fault event inputs, one bit each
    typedef struct packed {
        logic undervolt;
        logic overspeed;
        logic ovl_inst;
        logic ovl_sust;
        logic dbrake_ovl;
        logic inrush_ovl;
        logic heatsink_hot;
        logic enc_backup;
        logic enc_cksum;
        logic enc_batt;
        logic enc_internal;
        logic enc_overspeed;
        logic enc_hot;
        logic system_err;
        logic enc_link;
        logic runaway;
        logic multiturn_data;
        logic enc_param;
        logic enc_data;
        logic multiturn_mismatch;
        logic option_missing;
        logic phase_missing;
    } sfce_fault_in_s;
    // caution inputs
    typedef struct packed {
        logic ovl_warn;
        logic regen_warn;
        logic batt_low;
    } sfce_caut_in_s;
    // a/d read supervision inputs
    typedef struct packed {
        logic spd_start;
        logic spd_done;
        logic trq_start;
        logic trq_done;
    } sfce_ad_in_s;
    // pin outputs
    typedef struct packed {
        logic fault_output;
        logic [2:0] caution_out;
        logic fault_code_bit0;
        logic fault_code_bit1;
        logic fault_code_bit2;
        logic power_stage_enable;
        logic panel_link_err;
    } sfce_pins_s;
    // whole state
    typedef struct packed {
        logic fault_act;
        logic [2:0] fcode;
        logic sticky;
        logic [5:0] pend;
        logic panel_err;
        logic spd_busy;
        logic trq_busy;
        logic [15:0] spd_cnt;
        logic [15:0] trq_cnt;
        logic [31:0] cfg;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [31:0] pos_limit;
        sfce_pins_s pins;
    } sfce_state_s;
endpackage

// >>> sfce_top.sv
// servo fault and caution code encoder with apb control
`timescale 1ns/1ns
`default_nettype none
`include "sfce_defs.svh"
// apb slave for control, plus level inputs from the detectors
// fault, stage and caution pins idle high, code lines idle low
// every output leaves a flop, so the host never sees a glitch
module sfce_top
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire sfce_pkg::sfce_fault_in_s fault_in,
    input wire sfce_pkg::sfce_caut_in_s caut_in,
    input wire sfce_pkg::sfce_ad_in_s ad_in,
    input wire logic [31:0] position_error,
    input wire logic [31:0] load_deviation,
    input wire logic [31:0] load_deviation_limit,
    input wire logic panel_tx_fail,
    input wire logic panel_tx_timeout,
    input wire logic fault_clear,
    output logic fault_output,
    output logic [2:0] caution_out,
    output logic fault_code_bit0,
    output logic fault_code_bit1,
    output logic fault_code_bit2,
    output logic power_stage_enable,
    output logic panel_link_err
);
    // extra apb offset for the position error limit
    localparam logic [11:0] OFF_POSLIM = 12'h010;
    localparam logic [15:0] AD_TMO = 16'(`SFCE_AD_TMO_CYC);
    // register map seen by software
    // ctrl 000: writing one to bit0 asks for a clear
    // ctrl reads back as zero
    // stat 004: read only; code, fault, caution, panel, latch
    // cfg 008: bit0 caution code select, bits 5:4 terminal
    // raw 00c: read only, the power-cycle latches
    // poslim 010: position error limit, all ones at reset
    // all ones keeps the deviation check quiet until software
    // has set a real limit
    // the a/d timeout is a fixed count, not a register;
    // a slower converter would need a longer count here
    // trade-off: saves a register and its decode

    // one packed struct holds all state, registered in one place
    sfce_pkg::sfce_state_s st_r; // registered state
    sfce_pkg::sfce_state_s st_nxt; // next state
    logic [2:0] new_code; // code of highest ranked new fault
    logic new_any; // any fault event this cycle
    logic [5:0] pend_set; // faults that need a power cycle
    logic soft_clr; // clear from pin or register
    logic [2:0] caut_code; // caution code by rank
    logic caut_any; // any caution active
    logic spd_tmo; // speed a/d timed out
    logic trq_tmo; // torque a/d timed out
    logic wr_en; // apb write access
    logic rd_en; // apb read access

    // a/d busy counter step, shared by both channels
    function automatic logic [15:0] ad_step(input logic busy, input logic [15:0] cnt);
        ad_step = busy ? ((cnt == AD_TMO) ? cnt : 16'(cnt + 16'h0001)) : 16'h0000;
    endfunction

    // fault to code mapping, earlier branch wins when events coincide
    // the ranking only matters in the first cycle of a fault:
    // once a fault is latched, later events leave the code alone
    // several detections share one code, so the host cannot
    // tell them apart from the lines alone
    // position and load checks are plain unsigned compares
    // limitation: a deviation exactly at its limit is no fault
    // new_any is set first and taken back in the quiet branch
    always_comb
    begin
        new_any = 1'b1;
        new_code = 3'h0;
        if (fault_in.undervolt)
        begin
            new_code = `SFCE_CODE_UV;
        end
        else if (fault_in.overspeed)
        begin
            new_code = `SFCE_CODE_OS;
        end
        else if (fault_in.ovl_inst)
        begin
            new_code = `SFCE_CODE_OL;
        end
        else if (fault_in.ovl_sust)
        begin
            new_code = `SFCE_CODE_OL;
        end
        else if (fault_in.dbrake_ovl | fault_in.inrush_ovl | fault_in.heatsink_hot)
        begin
            new_code = `SFCE_CODE_OL;
        end
        // absolute encoder group, code zero for all
        else if (fault_in.enc_backup | fault_in.enc_cksum | fault_in.enc_batt | fault_in.enc_internal
                 | fault_in.enc_hot)
        begin
            new_code = `SFCE_CODE_ENC;
        end
        else if (fault_in.enc_overspeed)
        begin
            new_code = `SFCE_CODE_ENC;
        end
        // converter watch, fed by the busy counters
        else if (spd_tmo | trq_tmo)
        begin
            new_code = `SFCE_CODE_ENC;
        end
        else if (fault_in.system_err)
        begin
            new_code = `SFCE_CODE_ENC;
        end
        else if (fault_in.enc_link | fault_in.runaway | fault_in.multiturn_data | fault_in.enc_param
                 | fault_in.enc_data)
        begin
            new_code = `SFCE_CODE_LINK;
        end
        else if (fault_in.multiturn_mismatch)
        begin
            new_code = `SFCE_CODE_LINK;
        end
        else if (position_error > st_r.pos_limit)
        begin
            new_code = `SFCE_CODE_DEV;
        end
        else if (load_deviation > load_deviation_limit)
        begin
            new_code = `SFCE_CODE_DEV;
        end
        else if (fault_in.option_missing)
        begin
            new_code = `SFCE_CODE_OPT;
        end
        else if (fault_in.phase_missing)
        begin
            new_code = `SFCE_CODE_PH;
        end
        else
        begin
            new_any = 1'b0; // quiet
        end
    end

    // cautions ranked overload, regeneration, battery
    // a caution never latches: it follows its input a cycle late
    // and drops as soon as the condition goes away
    // the ranking picks one code when cautions overlap
    // operation goes on; nothing here touches the stage enable
    always_comb
    begin
        caut_any = 1'b1;
        caut_code = 3'h0;
        if (caut_in.ovl_warn)
        begin
            caut_code = `SFCE_CODE_W_OL;
        end
        else if (caut_in.regen_warn)
        begin
            caut_code = `SFCE_CODE_W_RG;
        end
        else if (caut_in.batt_low)
        begin
            caut_code = `SFCE_CODE_W_BAT;
        end
        else
        begin
            caut_any = 1'b0; // none
        end
    end

    // power-cycle-only sources; a soft clear cannot drop these
    // the latches stay set until presetn, so a clear request
    // while any of them is set leaves the fault standing
    // a timeout flag stays high while its channel stays busy,
    // so a done pulse must come before a clear can take
    assign pend_set = {fault_in.enc_backup, fault_in.enc_cksum, fault_in.enc_internal,
                       fault_in.enc_link, fault_in.system_err, fault_in.multiturn_data};
    assign spd_tmo = st_r.spd_busy & (st_r.spd_cnt == AD_TMO);
    assign trq_tmo = st_r.trq_busy & (st_r.trq_cnt == AD_TMO);
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;
    assign soft_clr = fault_clear | (wr_en & (paddr == `SFCE_OFF_CTRL) & pwdata[`SFCE_CTRL_CLR_BIT]);

    // next state of the whole block
    // every field starts from its old value
    // the answer strobes start low; only an access raises them
    // order matters below: clear, then latch, then new faults,
    // so that a fault in the clear cycle still wins
    // a/d channels: start arms the watch, done drops it,
    // and the counter saturates at the timeout count
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.pready = 1'b0;
        st_nxt.pslverr = 1'b0;
        // a/d supervision: start arms, done disarms
        st_nxt.spd_busy = (st_r.spd_busy | ad_in.spd_start) & ~ad_in.spd_done;
        st_nxt.trq_busy = (st_r.trq_busy | ad_in.trq_start) & ~ad_in.trq_done;
        st_nxt.spd_cnt = ad_step(st_r.spd_busy, st_r.spd_cnt);
        st_nxt.trq_cnt = ad_step(st_r.trq_busy, st_r.trq_cnt);
        // clear first; any new event this cycle overrides it
        if (soft_clr && st_r.pend == 6'h00)
        begin
            st_nxt.fault_act = 1'b0;
            st_nxt.fcode = 3'h0;
            st_nxt.panel_err = 1'b0;
        end
        st_nxt.pend = st_r.pend | pend_set;
        // first fault takes the lines; later ones only keep it set
        // a fault in the clear cycle replaces the cleared code
        // panel errors latch apart from faults and carry no code
        if (new_any && !st_r.fault_act)
        begin
            st_nxt.fault_act = 1'b1;
            st_nxt.fcode = new_code;
        end
        else if (new_any && soft_clr && st_r.pend == 6'h00)
        begin
            st_nxt.fault_act = 1'b1; // set beats clear
            st_nxt.fcode = new_code;
        end
        if (panel_tx_fail | panel_tx_timeout)
        begin
            st_nxt.panel_err = 1'b1;
        end
        // apb write side
        // read-only or unmapped words only flag an error
        // ctrl writes only pulse the clear, nothing is stored
        // the access phase lasts two cycles, so a write lands twice;
        // harmless, the same data is stored again
        if (wr_en)
        begin
            st_nxt.pready = 1'b1;
            case (paddr)
                `SFCE_OFF_CTRL: st_nxt.pslverr = 1'b0;
                `SFCE_OFF_CFG: st_nxt.cfg = pwdata;
                OFF_POSLIM: st_nxt.pos_limit = pwdata;
                default: st_nxt.pslverr = 1'b1; // unmapped or read-only
            endcase
        end
        // apb read side
        // status bits come from the old state, one cycle stale, except the caution bit, taken from the live inputs;
        // the host polls, so this costs nothing
        // reads have no side effects, no flag clears on read
        if (rd_en)
        begin
            st_nxt.pready = 1'b1;
            case (paddr)
                `SFCE_OFF_CTRL: st_nxt.prdata = 32'h0000_0000;
                `SFCE_OFF_STAT: st_nxt.prdata = {24'h00_0000, |st_r.pend, st_r.panel_err, caut_any,
                                                  st_r.fault_act, 1'b0, st_r.fcode};
                `SFCE_OFF_CFG: st_nxt.prdata = st_r.cfg;
                `SFCE_OFF_RAW: st_nxt.prdata = {26'h000_0000, st_r.pend};
                OFF_POSLIM: st_nxt.prdata = st_r.pos_limit;
                default:
                begin
                    st_nxt.prdata = 32'h0000_0000;
                    st_nxt.pslverr = 1'b1; // unmapped
                end
            endcase
        end
        // one-cycle answer, drop after the access edge
        // the second access cycle would raise pready again;
        // forcing it low keeps the answer a single pulse
        // prdata keeps its value until the next read
        if (st_r.pready)
        begin
            st_nxt.pready = 1'b0;
            st_nxt.pslverr = 1'b0;
        end
        // pins from the updated state
        // built from the next state, so they flip on the same edge
        // as the fault latch and still leave a flop
        // caution terminals idle high; one goes low when assigned
        // fault beats caution on the code lines
        st_nxt.pins.fault_output = ~st_nxt.fault_act;
        st_nxt.pins.power_stage_enable = ~st_nxt.fault_act;
        st_nxt.pins.panel_link_err = st_nxt.panel_err;
        st_nxt.pins.caution_out = 3'h7;
        if (caut_any && st_r.cfg[`SFCE_CFG_PIN_LSB +: `SFCE_CFG_PIN_W] != 2'h0)
        begin
            // terminal 1..3 chosen; zero means not assigned
            st_nxt.pins.caution_out[2'(st_r.cfg[`SFCE_CFG_PIN_LSB +: `SFCE_CFG_PIN_W] - 2'h1)] = 1'b0;
        end
        if (st_nxt.fault_act)
        begin
            {st_nxt.pins.fault_code_bit2, st_nxt.pins.fault_code_bit1, st_nxt.pins.fault_code_bit0} =
                st_nxt.fcode;
        end
        else if (caut_any && st_r.cfg[`SFCE_CFG_CSEL_BIT])
        begin
            {st_nxt.pins.fault_code_bit2, st_nxt.pins.fault_code_bit1, st_nxt.pins.fault_code_bit0} =
                caut_code;
        end
        else
        begin
            {st_nxt.pins.fault_code_bit2, st_nxt.pins.fault_code_bit1, st_nxt.pins.fault_code_bit0} = 3'h0;
        end
    end

    // single state register
    // reset loads constants only; pins start at safe idle levels
    // so the stage may run until the first fault
    // cfg resets with caution codes on and no terminal chosen
    // the position limit resets to all ones, check disabled
    // the whole struct clears first, then fields get their values
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r <= '0;
            st_r.cfg <= `SFCE_CFG_RESET; // caution codes on by default
            st_r.pos_limit <= 32'hFFFF_FFFF;
            st_r.pins.fault_output <= 1'b1;
            st_r.pins.caution_out <= 3'h7;
            st_r.pins.power_stage_enable <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from flops
    // no logic after the flops, so the host sees clean levels
    // and no glitch reaches the fault or stage pins
    // the apb answer signals come from the same register
    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign fault_output = st_r.pins.fault_output;
    assign caution_out = st_r.pins.caution_out;
    assign fault_code_bit0 = st_r.pins.fault_code_bit0;
    assign fault_code_bit1 = st_r.pins.fault_code_bit1;
    assign fault_code_bit2 = st_r.pins.fault_code_bit2;
    assign power_stage_enable = st_r.pins.power_stage_enable;
    assign panel_link_err = st_r.pins.panel_link_err;
endmodule
`default_nettype wire

// >>> sfce_monitor.sv
// checker for the fault code encoder ports
`timescale 1ns/1ns
`default_nettype none
module sfce_monitor
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire sfce_pkg::sfce_fault_in_s fault_in,
    input wire sfce_pkg::sfce_caut_in_s caut_in,
    input wire logic fault_clear,
    input wire logic fault_output,
    input wire logic [2:0] caution_out,
    input wire logic fault_code_bit0,
    input wire logic fault_code_bit1,
    input wire logic fault_code_bit2,
    input wire logic power_stage_enable,
    input wire logic panel_link_err
);
    // code lines gathered, bit0 lowest
    logic [2:0] code;
    assign code = {fault_code_bit2, fault_code_bit1, fault_code_bit0};
    // clear written through the control word, seen at the access
    logic reg_clr;
    assign reg_clr = psel && penable && pwrite && (paddr == 12'h000) && pwdata[0];
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // setup cycle then first access cycle
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        s_setup ##1 (psel && penable);
    endsequence
    chk_apb_answer: assert property (s_access |=> pready)
        else $error("apb access not answered in one cycle");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    chk_fault_drop: assert property ((fault_in != '0) |=> !fault_output)
        else $error("fault output not low after fault");
    chk_stage_off: assert property (!fault_output |-> !power_stage_enable)
        else $error("power stage running during fault");
    chk_stage_runs: assert property (fault_output |-> power_stage_enable)
        else $error("power stage stopped without fault");
    chk_uv_code: assert property (fault_output && fault_in.undervolt |=> code == 3'h4)
        else $error("undervoltage code wrong");
    chk_os_code: assert property (fault_output && fault_in.overspeed && !fault_in.undervolt
        |=> code == 3'h5)
        else $error("overspeed code wrong");
    // a held fault keeps its code until cleared
    chk_code_held: assert property (!fault_output && !fault_clear && !reg_clr && !panel_link_err
        |=> !fault_output && $stable(code))
        else $error("fault code changed while held");
    chk_caut_idle: assert property (caut_in == '0 |=> caution_out == 3'h7)
        else $error("caution output low without caution");
endmodule
bind sfce_top sfce_monitor i_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .fault_in, .caut_in,
    .fault_clear, .fault_output, .caution_out, .fault_code_bit0, .fault_code_bit1, .fault_code_bit2,
    .power_stage_enable, .panel_link_err);
`default_nettype wire

// >>> sfce_host.sv
// host controller model reading the fault code lines
`timescale 1ns/1ns
`default_nettype none
module sfce_host
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic fault_output,
    input wire logic [2:0] code_lines,
    output logic [2:0] first_code
);
    // previous fault output level, to see the drop
    logic fault_d_r;
    // code lines are only trusted at the drop of the fault output
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fault_d_r <= 1'b1;
            first_code <= 3'h0;
        end
        else
        begin
            fault_d_r <= fault_output;
            if (fault_d_r && !fault_output)
                first_code <= code_lines;
        end
    end
endmodule
`default_nettype wire

// >>> servo_fault_code_encoder_bench.sv
// self-checking bench for the fault code encoder
`timescale 1ns/1ns
`default_nettype none
module servo_fault_code_encoder_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    sfce_pkg::sfce_fault_in_s fault_in = '0;
    sfce_pkg::sfce_caut_in_s caut_in = '0;
    sfce_pkg::sfce_ad_in_s ad_in = '0;
    logic [31:0] position_error = 32'h0000_0000;
    logic [31:0] load_deviation = 32'h0000_0000;
    logic [31:0] load_deviation_limit = 32'hFFFF_FFFF;
    logic [1:0] panel_req = 2'h0; // timeout, fail
    logic fault_clear = 1'b0;
    logic fault_output;
    logic [2:0] caution_out;
    logic fault_code_bit0;
    logic fault_code_bit1;
    logic fault_code_bit2;
    logic power_stage_enable;
    logic panel_link_err;
    logic [2:0] host_code;
    logic [31:0] rd; // last read data
    logic er; // last pslverr
    int mismatches = 0;
    int samples_checked = 0;
    int n;
    // expected code per fault input, input 0 in lowest nibble
    localparam logic [87:0] CODE_TBL = 88'h4577777000000055555562;
    // inputs whose fault only a power cycle clears
    localparam logic [21:0] PWR_ONLY = 22'h0069A0;
    // fault out, stage enable, code bits 2..0; idle is 18
    wire logic [4:0] pins = {fault_output, power_stage_enable, fault_code_bit2, fault_code_bit1, fault_code_bit0};
    always #5 pclk = ~pclk;
    sfce_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .fault_in, .caut_in, .ad_in, .position_error, .load_deviation, .load_deviation_limit,
        .panel_tx_fail(panel_req[0]), .panel_tx_timeout(panel_req[1]), .fault_clear, .fault_output,
        .caution_out, .fault_code_bit0, .fault_code_bit1, .fault_code_bit2, .power_stage_enable,
        .panel_link_err);
    sfce_host i_host (.pclk, .presetn, .fault_output, .code_lines(pins[2:0]), .first_code(host_code));
    task finish_test;
        if (mismatches == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task step;
        @(posedge pclk);
    endtask
    // outputs are settled by the falling edge
    task look;
        @(negedge pclk);
    endtask
    task cmp(input logic [31:0] g, input logic [31:0] x);
        samples_checked++;
        if (g !== x)
        begin
            mismatches++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    // one apb transfer, waits for pready under a bound
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        step;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        step;
        penable <= 1'b1;
        k = 0;
        do
        begin
            step;
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20)
        begin
            mismatches++;
            finish_test;
        end
    endtask
    task clr;
        step;
        fault_clear <= 1'b1;
        step;
        fault_clear <= 1'b0;
        look;
    endtask
    task rst;
        step;
        presetn <= 1'b0;
        step;
        step;
        presetn <= 1'b1;
    endtask
    initial
    begin
        step;
        step;
        presetn <= 1'b1;
        apb(1'b0, 12'h008, 32'h0);
        cmp(rd, 32'h1);
        apb(1'b0, 12'h020, 32'h0);
        cmp(32'(er), 32'h1);
        apb(1'b1, 12'h004, 32'h1);
        cmp(32'(er), 32'h1);
        // each fault input alone, then a clear attempt
        for (int i = 0; i < 22; i++)
        begin
            step;
            fault_in <= 22'h1 << i;
            step;
            fault_in <= '0;
            look;
            cmp(32'(pins), {29'h0, CODE_TBL[i*4 +: 3]});
            clr;
            cmp(32'(pins), PWR_ONLY[i] ? {29'h0, CODE_TBL[i*4 +: 3]} : 32'h18);
            if (PWR_ONLY[i])
                rst;
        end
        // first fault held, then clear through the control register
        step;
        fault_in <= 22'h200000;
        caut_in <= 3'h4;
        step;
        fault_in <= 22'h100000;
        caut_in <= 3'h0;
        step;
        fault_in <= '0;
        look;
        cmp(32'(pins), 32'h04);
        cmp(32'(host_code), 32'h4);
        apb(1'b0, 12'h004, 32'h0);
        cmp(rd, 32'h0000_0014);
        apb(1'b1, 12'h000, 32'h1);
        look;
        cmp(32'(pins), 32'h18);
        // cautions on each terminal in turn, operation continues
        for (int j = 0; j < 3; j++)
        begin
            apb(1'b1, 12'h008, 32'h1 | (32'(j + 1) << 4));
            step;
            caut_in <= 3'h4 >> j;
            step;
            caut_in <= 3'h0;
            look;
            cmp(32'(pins), 32'h18 + 32'(j + 1));
            cmp(32'(caution_out), 32'h7 & ~(32'h1 << j));
        end
        apb(1'b1, 12'h008, 32'h0);
        step;
        caut_in <= 3'h1;
        step;
        caut_in <= 3'h0;
        look;
        cmp(32'(pins), 32'h18);
        cmp(32'(caution_out), 32'h7);
        // position error at and above the limit
        apb(1'b1, 12'h010, 32'h5);
        step;
        position_error <= 32'h5;
        step;
        step;
        look;
        cmp(32'(pins), 32'h18);
        step;
        position_error <= 32'h6;
        step;
        position_error <= 32'h0;
        look;
        cmp(32'(pins), 32'h03);
        clr;
        step;
        load_deviation_limit <= 32'h9;
        load_deviation <= 32'hA;
        step;
        load_deviation <= 32'h0;
        look;
        cmp(32'(pins), 32'h03);
        clr;
        // converter done never comes
        step;
        ad_in <= 4'h8;
        step;
        ad_in <= 4'h0;
        repeat (9990) step;
        look;
        cmp(32'(pins), 32'h18);
        n = 0;
        while (fault_output !== 1'b0 && n < 30)
        begin
            look;
            n++;
        end
        cmp(32'(pins), 32'h00);
        cmp(32'(n), 32'h0000_000B);
        if (n >= 30)
        begin
            mismatches++;
            finish_test;
        end
        // done disarms the stuck watch, else the clear is overridden
        step;
        ad_in <= 4'h4;
        step;
        ad_in <= 4'h0;
        clr;
        cmp(32'(pins), 32'h18);
        step;
        ad_in <= 4'h2;
        step;
        ad_in <= 4'h1;
        step;
        ad_in <= 4'h0;
        repeat (10010) step;
        look;
        cmp(32'(pins), 32'h18);
        // panel link errors carry no code
        for (int k = 1; k < 3; k++)
        begin
            step;
            panel_req <= 2'(k);
            step;
            panel_req <= 2'h0;
            look;
            cmp(32'(panel_link_err), 32'h1);
            cmp(32'(pins[2:0]), 32'h0);
            clr;
            cmp(32'(panel_link_err), 32'h0);
        end
        finish_test;
    end
endmodule
`default_nettype wire
